// >>> swm_pkg.sv
// Shared constants of the sleep and wake manager and its host.
// Assumes a 100 MHz system clock on both ends.
package swm_pkg;
    localparam int unsigned SYS_CLK_HZ = 100_000_000;
    localparam int unsigned LF_CLK_HZ = 32_000;
    // System cycles per low-frequency tick, rounded down
    localparam logic [11:0] LF_DIV = 12'(SYS_CLK_HZ / LF_CLK_HZ);
    localparam int unsigned AW = 4;
    localparam int unsigned DW = 16;
    // Device register indices, reached over the link
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_WAKE_EN = 4'h1;
    localparam logic [3:0] REG_TIMEOUT = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_IRQ_CLR = 4'h4;
    // Control fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_RETAIN = 2;
    localparam int unsigned CTRL_IRQ_POL = 3;
    localparam int unsigned CTRL_GPIO_POL = 4;
    localparam logic [1:0] MODE_LIGHT = 2'h1;
    localparam logic [1:0] MODE_DEEP = 2'h2;
    localparam logic CTRL_IRQ_POL_RST = 1'b1;
    localparam logic [4:0] WAKE_EN_RST = 5'h1F;
    localparam logic [15:0] TIMEOUT_RST = 16'hFFFF;
    // Wake source bits, also the wake-cause layout
    localparam int unsigned WK_TIMER = 0;
    localparam int unsigned WK_GPIO = 1;
    localparam int unsigned WK_COMP = 2;
    localparam int unsigned WK_RTC = 3;
    localparam int unsigned WK_WDOG = 4;
    localparam int unsigned NWK = 5;
    // Host interface selection strap
    localparam logic [1:0] IF_USB = 2'h3;
    // Host register addresses
    localparam logic [3:0] HREG_CTRL = 4'h0;
    localparam logic [3:0] HREG_ADDR = 4'h1;
    localparam logic [3:0] HREG_WDATA = 4'h2;
    localparam logic [3:0] HREG_RDATA = 4'h3;
    localparam logic [3:0] HREG_STAT = 4'h4;
    localparam int unsigned HC_RUN = 0;
    localparam int unsigned HC_WANT = 1;
    localparam int unsigned HC_INIT = 2;
    localparam int unsigned HC_POLDONE = 3;
    localparam int unsigned HC_POL = 4;
    localparam int unsigned HA_WE = 15;
    // Cycles the host waits for an acknowledge before giving up
    localparam logic [2:0] ACK_WAIT = 3'h4;
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_LIGHT = 2'b01,
        ST_DEEP = 2'b11
    } swm_state_e;
endpackage

// >>> swm_if.sv
// Link between host processor and device: register access, interrupt, reset, serial lines.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface swm_if;
    import swm_pkg::*;
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic ack;
    logic [DW-1:0] rdata;
    logic host_irq_out;
    logic dev_rst;
    logic uart_tx;
    logic uart_tx_oe;
    logic uart_cts_n;
    logic uart_cts_oe;
    modport dev (
        input req, we, addr, wdata, dev_rst, uart_tx, uart_tx_oe, uart_cts_n, uart_cts_oe,
        output ack, rdata, host_irq_out
    );
    modport host (
        output req, we, addr, wdata, dev_rst, uart_tx, uart_tx_oe, uart_cts_n, uart_cts_oe,
        input ack, rdata, host_irq_out
    );
endinterface
`default_nettype wire

// >>> swm_device.sv
// Device end: sleep and wake manager with its link-side register file.
// Assumes link inputs are synchronous to I_SYS_CLK and wake inputs are already clean levels.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Deep sleep: manager owns every subsystem sleep
// - Deep sleep: always-on domain on 32 kHz
// - Deep sleep with or without RAM retention
// - Deep sleep ends after programmed timeout
// - Deep sleep wake on GPIO polarity match
// - Deep sleep wake on comparator event
// - Deep sleep wake on RTC timeout
// - Deep sleep wake on watchdog interrupt
// - No deep sleep with USB host interface
// - Light sleep keeps state, gates fast clocks
// - Light sleep still accepts host commands
// - Command ungates clock, serves, regates
// - Light sleep wake on GPIO
// - Light sleep wake after timeout
// - Interrupt output polarity is configurable
// - Host keeps interrupt off until reset release
// - Host enables interrupt after init, polarity
// - Host disables interrupt across deep sleep
// - Host drives serial lines before release
// - Interface selection kept from power-up
module swm_device
    import swm_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    input wire logic I_CLK_EN,
    input wire logic [1:0] I_HOST_IF_SEL,
    input wire logic I_GPIO_WAKE,
    input wire logic I_COMP_EVT,
    input wire logic I_RTC_TIMEOUT,
    input wire logic I_WDOG_IRQ,
    output logic O_HF_CLK_EN,
    output logic O_AON_LF_SEL,
    output logic O_RAM_RETAIN,
    output logic [3:0] O_SUBSYS_SLEEP,
    output logic [1:0] O_STATE,
    swm_if.dev LINK
);
    swm_state_e state_r;
    swm_state_e state_nxt;
    logic [11:0] lf_cnt_r;
    logic [15:0] sleep_cnt_r;
    logic if_cap_r;
    logic [1:0] if_sel_r;
    logic retain_r;
    logic irq_pol_r;
    logic gpio_pol_r;
    logic [NWK-1:0] wake_en_r;
    logic [15:0] timeout_r;
    logic [NWK-1:0] cause_r;
    logic irq_pend_r;
    logic refused_r;
    logic ack_r;
    logic [DW-1:0] rdata_r;
    logic irq_r;
    logic hf_r;
    logic lf_sel_r;
    logic retain_out_r;
    logic [3:0] subsys_r;

    // Link reset from the host acts like the system reset
    wire rst = I_RESET | LINK.dev_rst;
    wire en = I_CLK_EN;

    // Low-frequency tick: the always-on timer advances only on it
    wire lf_tick = (lf_cnt_r == LF_DIV - 12'h001);

    // Requests are served in every state but deep sleep
    wire serve = LINK.req & (state_r != ST_DEEP);
    wire wr = serve & LINK.we;
    wire wr_ctrl = wr & (LINK.addr == REG_CTRL);
    wire wr_wake = wr & (LINK.addr == REG_WAKE_EN);
    wire wr_tmo = wr & (LINK.addr == REG_TIMEOUT);
    wire wr_iclr = wr & (LINK.addr == REG_IRQ_CLR);
    wire [1:0] mode_req = LINK.wdata[CTRL_MODE_LSB +: 2];
    wire usb_sel = (if_sel_r == IF_USB);
    wire go_light = wr_ctrl & (state_r == ST_ACTIVE) & (mode_req == MODE_LIGHT);
    wire go_deep_req = wr_ctrl & (state_r == ST_ACTIVE) & (mode_req == MODE_DEEP);
    wire go_deep = go_deep_req & ~usb_sel;

    // Wake sources; light sleep listens to timer and GPIO only
    wire tmr_hit = (sleep_cnt_r >= timeout_r);
    wire gpio_hit = (I_GPIO_WAKE == gpio_pol_r);
    wire [NWK-1:0] raw_src = {I_WDOG_IRQ, I_RTC_TIMEOUT, I_COMP_EVT, gpio_hit, tmr_hit};
    wire [NWK-1:0] light_mask = (NWK'(1) << WK_TIMER) | (NWK'(1) << WK_GPIO);
    wire [NWK-1:0] deep_src = raw_src & wake_en_r;
    wire [NWK-1:0] light_src = raw_src & wake_en_r & light_mask;
    wire [NWK-1:0] src = (state_r == ST_DEEP) ? deep_src : light_src;
    wire asleep = (state_r != ST_ACTIVE);
    wire wake = asleep & (|src);

    // Interrupt pending: a wake wins over a clear in the same cycle
    wire irq_pend_nxt = wake | (irq_pend_r & ~(wr_iclr & LINK.wdata[0]));
    wire irq_pol_nxt = wr_ctrl ? LINK.wdata[CTRL_IRQ_POL] : irq_pol_r;

    // Read mux, status carries live state
    wire [DW-1:0] status = {4'h0, refused_r, if_sel_r, 1'b0, cause_r, irq_pend_r, state_r};
    wire [DW-1:0] ctrl_rd = DW'({gpio_pol_r, irq_pol_r, retain_r, 2'b00});
    logic [DW-1:0] rd_mux;
    always_comb
    begin
        unique case (LINK.addr)
            REG_CTRL: rd_mux = ctrl_rd;
            REG_WAKE_EN: rd_mux = DW'(wake_en_r);
            REG_TIMEOUT: rd_mux = timeout_r;
            REG_STATUS: rd_mux = status;
            default: rd_mux = '0;
        endcase
    end

    // State sequence: active to a sleep on request, back to active on wake
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_ACTIVE:
            begin
                if (go_deep)
                    state_nxt = ST_DEEP;
                else if (go_light)
                    state_nxt = ST_LIGHT;
            end
            ST_LIGHT, ST_DEEP:
            begin
                if (wake)
                    state_nxt = ST_ACTIVE;
            end
            default: state_nxt = ST_ACTIVE;
        endcase
    end

    wire deep_nxt = (state_nxt == ST_DEEP);
    // Fast clocks run when active or for the one cycle a request is served
    // The command that enters deep sleep must not leave the fast clock on
    wire hf_nxt = (state_nxt == ST_ACTIVE) | (serve & ~deep_nxt);

    // Tick divider and sleep timer
    always_ff @(posedge I_SYS_CLK)
    begin
        if (rst)
        begin
            lf_cnt_r <= '0;
            sleep_cnt_r <= '0;
        end
        else if (en)
        begin
            lf_cnt_r <= lf_tick ? 12'h000 : lf_cnt_r + 12'h001;
            if (go_light | go_deep)
                sleep_cnt_r <= '0;
            else if (asleep & lf_tick & ~tmr_hit)
                sleep_cnt_r <= sleep_cnt_r + 16'h0001;
        end
    end

    // Strap capture one edge after release, then held for every wake
    always_ff @(posedge I_SYS_CLK)
    begin
        if (rst)
        begin
            if_cap_r <= 1'b0;
            if_sel_r <= 2'h0;
        end
        else if (en & ~if_cap_r)
        begin
            if_cap_r <= 1'b1;
            if_sel_r <= I_HOST_IF_SEL;
        end
    end

    // Register file written over the link
    always_ff @(posedge I_SYS_CLK)
    begin
        if (rst)
        begin
            retain_r <= 1'b0;
            irq_pol_r <= CTRL_IRQ_POL_RST;
            gpio_pol_r <= 1'b1;
            wake_en_r <= WAKE_EN_RST;
            timeout_r <= TIMEOUT_RST;
            refused_r <= 1'b0;
        end
        else if (en)
        begin
            if (wr_ctrl)
            begin
                retain_r <= LINK.wdata[CTRL_RETAIN];
                irq_pol_r <= irq_pol_nxt;
                gpio_pol_r <= LINK.wdata[CTRL_GPIO_POL];
                refused_r <= go_deep_req & usb_sel;
            end
            if (wr_wake)
                wake_en_r <= LINK.wdata[NWK-1:0];
            if (wr_tmo)
                timeout_r <= LINK.wdata;
        end
    end

    // State, cause, interrupt and link answer
    always_ff @(posedge I_SYS_CLK)
    begin
        if (rst)
        begin
            state_r <= ST_ACTIVE;
            cause_r <= '0;
            irq_pend_r <= 1'b0;
            irq_r <= ~CTRL_IRQ_POL_RST;
            ack_r <= 1'b0;
            rdata_r <= '0;
        end
        else if (en)
        begin
            state_r <= state_nxt;
            if (wake)
                cause_r <= src;
            irq_pend_r <= irq_pend_nxt;
            irq_r <= ~(irq_pend_nxt ^ irq_pol_nxt);
            ack_r <= serve;
            if (serve & ~LINK.we)
                rdata_r <= rd_mux;
        end
    end

    // Power outputs follow the next state so they line up with O_STATE
    always_ff @(posedge I_SYS_CLK)
    begin
        if (rst)
        begin
            hf_r <= 1'b1;
            lf_sel_r <= 1'b0;
            retain_out_r <= 1'b0;
            subsys_r <= 4'h0;
        end
        else if (en)
        begin
            hf_r <= hf_nxt;
            lf_sel_r <= deep_nxt;
            retain_out_r <= deep_nxt & (go_deep ? LINK.wdata[CTRL_RETAIN] : retain_r);
            subsys_r <= {4{deep_nxt}};
        end
    end

    assign O_STATE = state_r;
    assign O_HF_CLK_EN = hf_r;
    assign O_AON_LF_SEL = lf_sel_r;
    assign O_RAM_RETAIN = retain_out_r;
    assign O_SUBSYS_SLEEP = subsys_r;
    assign LINK.ack = ack_r;
    assign LINK.rdata = rdata_r;
    assign LINK.host_irq_out = irq_r;
endmodule // swm_device
`default_nettype wire

// >>> swm_host.sv
// Host end: drives device reset, serial lines and register access; gates its interrupt input.
// Assumes a software port with one-cycle strobes and read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module swm_host
    import swm_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    input wire logic I_CLK_EN,
    input wire logic [3:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [15:0] O_RDATA,
    output logic O_IRQ_EN,
    swm_if.host LINK
);
    logic run_r;
    logic want_r;
    logic init_r;
    logic pol_done_r;
    logic pol_r;
    logic cmd_we_r;
    logic [AW-1:0] cmd_addr_r;
    logic busy_r;
    logic [2:0] wait_r;
    logic err_r;
    logic seen_r;
    logic [DW-1:0] ans_r;
    logic irq_en_r;
    logic req_r;
    logic [DW-1:0] wdata_r;
    logic [15:0] rdata_r;
    logic dev_rst_r;

    wire en = I_CLK_EN;
    wire wr_ctrl = I_WR & (I_ADDR == HREG_CTRL);
    wire wr_addr = I_WR & (I_ADDR == HREG_ADDR);
    wire wr_stat = I_WR & (I_ADDR == HREG_STAT);
    // A new command is refused while one is outstanding
    wire issue = I_WR & (I_ADDR == HREG_WDATA) & ~busy_r;
    wire to_deep = issue & cmd_we_r & (cmd_addr_r == REG_CTRL)
        & (I_WDATA[CTRL_MODE_LSB +: 2] == MODE_DEEP);
    wire timed_out = busy_r & ~LINK.ack & (wait_r == ACK_WAIT);

    // Control bits; init and polarity only count once the device runs
    wire run_nxt = wr_ctrl ? I_WDATA[HC_RUN] : run_r;
    wire want_nxt = wr_ctrl ? I_WDATA[HC_WANT] : want_r;
    wire init_nxt = ~to_deep & run_nxt & run_r & (wr_ctrl ? I_WDATA[HC_INIT] : init_r);
    wire pol_done_nxt = ~to_deep & run_nxt & run_r & (wr_ctrl ? I_WDATA[HC_POLDONE] : pol_done_r);
    wire irq_en_nxt = run_nxt & want_nxt & init_nxt & pol_done_nxt;
    wire irq_hit = irq_en_r & (LINK.host_irq_out == pol_r);
    // Interrupt seen wins over a clear in the same cycle
    wire seen_nxt = irq_hit | (seen_r & ~(wr_stat & I_WDATA[0]));
    wire err_nxt = timed_out | (err_r & ~(wr_stat & I_WDATA[1]));

    logic [15:0] rd_mux;
    always_comb
    begin
        unique case (I_ADDR)
            HREG_CTRL: rd_mux = {11'h000, pol_r, pol_done_r, init_r, want_r, run_r};
            HREG_ADDR: rd_mux = {cmd_we_r, 11'h000, cmd_addr_r};
            HREG_WDATA: rd_mux = wdata_r;
            HREG_RDATA: rd_mux = ans_r;
            HREG_STAT: rd_mux = {12'h000, irq_en_r, busy_r, err_r, seen_r};
            default: rd_mux = '0;
        endcase
    end

    // Software registers and interrupt gating
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RESET)
        begin
            run_r <= 1'b0;
            want_r <= 1'b0;
            init_r <= 1'b0;
            pol_done_r <= 1'b0;
            pol_r <= 1'b1;
            cmd_we_r <= 1'b0;
            cmd_addr_r <= '0;
            irq_en_r <= 1'b0;
            seen_r <= 1'b0;
            err_r <= 1'b0;
            dev_rst_r <= 1'b1;
            rdata_r <= '0;
        end
        else if (en)
        begin
            run_r <= run_nxt;
            want_r <= want_nxt;
            init_r <= init_nxt;
            pol_done_r <= pol_done_nxt;
            if (wr_ctrl)
                pol_r <= I_WDATA[HC_POL];
            if (wr_addr)
            begin
                cmd_we_r <= I_WDATA[HA_WE];
                cmd_addr_r <= I_WDATA[AW-1:0];
            end
            irq_en_r <= irq_en_nxt;
            seen_r <= seen_nxt;
            err_r <= err_nxt;
            dev_rst_r <= ~run_nxt;
            if (I_RD)
                rdata_r <= rd_mux;
        end
    end

    // Command issue and acknowledge tracking
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RESET)
        begin
            req_r <= 1'b0;
            wdata_r <= '0;
            busy_r <= 1'b0;
            wait_r <= '0;
            ans_r <= '0;
        end
        else if (en)
        begin
            req_r <= issue;
            if (issue)
            begin
                wdata_r <= I_WDATA;
                busy_r <= 1'b1;
                wait_r <= '0;
            end
            else if (busy_r & LINK.ack)
            begin
                busy_r <= 1'b0;
                ans_r <= LINK.rdata;
            end
            else if (timed_out)
                busy_r <= 1'b0;
            else if (busy_r)
                wait_r <= wait_r + 3'h1;
        end
    end

    assign O_RDATA = rdata_r;
    assign O_IRQ_EN = irq_en_r;
    assign LINK.req = req_r;
    assign LINK.we = cmd_we_r;
    assign LINK.addr = cmd_addr_r;
    assign LINK.wdata = wdata_r;
    assign LINK.dev_rst = dev_rst_r;
    // Serial lines are defined from reset onward, well before the device leaves reset
    assign LINK.uart_tx = 1'b1;
    assign LINK.uart_tx_oe = 1'b1;
    assign LINK.uart_cts_n = 1'b0;
    assign LINK.uart_cts_oe = 1'b1;
endmodule // swm_host
`default_nettype wire

// >>> swm_props.sv
// Checker for the host-device link and the device sleep outputs.
// Assumes one clock, synchronous active-high reset and clock enables held high.
`timescale 1ns/1ps
`default_nettype none
module swm_props
    import swm_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    input wire logic req,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic ack,
    input wire logic host_irq_out,
    input wire logic dev_rst,
    input wire logic uart_tx,
    input wire logic uart_tx_oe,
    input wire logic uart_cts_n,
    input wire logic uart_cts_oe,
    input wire logic O_HF_CLK_EN,
    input wire logic O_AON_LF_SEL,
    input wire logic [3:0] O_SUBSYS_SLEEP,
    input wire logic [1:0] O_STATE,
    input wire logic O_IRQ_EN
);
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RESET);
    // A link write asking for deep sleep
    wire logic deep_req = req && we && addr == REG_CTRL && wdata[1:0] == MODE_DEEP;
    // Requests are answered one cycle later, except in deep sleep where nothing answers
    a_ack_exact: assert property (!$past(dev_rst) |-> ack == ($past(req) && $past(O_STATE) != ST_DEEP))
        else $error("ack does not follow request");
    a_reset_quiet: assert property (dev_rst |=> !ack && !host_irq_out && O_STATE == ST_ACTIVE)
        else $error("device not quiet in reset");
    a_lines_set: assert property (uart_tx_oe && uart_cts_oe && uart_tx && !uart_cts_n)
        else $error("serial lines undefined");
    a_irq_off_rst: assert property (dev_rst |-> !O_IRQ_EN)
        else $error("interrupt enabled in reset");
    a_irq_off_deep: assert property (deep_req |-> !O_IRQ_EN)
        else $error("interrupt enabled at deep entry");
    // Enable may only rise once the device is out of reset
    a_irq_late_on: assert property ($rose(O_IRQ_EN) |-> !$past(dev_rst))
        else $error("interrupt enabled too early");
    a_deep_outs: assert property (O_AON_LF_SEL == (O_STATE == ST_DEEP) && O_SUBSYS_SLEEP == {4{O_AON_LF_SEL}}
        && !(O_AON_LF_SEL && O_HF_CLK_EN))
        else $error("deep sleep outputs wrong");
    // The fast clock runs in light sleep only while a command is answered
    a_light_gate: assert property (O_STATE == ST_LIGHT && $past(O_STATE) == ST_LIGHT |-> O_HF_CLK_EN == ack)
        else $error("fast clock not gated in light sleep");
    cover property (O_STATE == ST_DEEP ##1 O_STATE == ST_ACTIVE);
    cover property (O_STATE == ST_LIGHT && ack);
    cover property (deep_req ##1 O_STATE == ST_ACTIVE);
endmodule // swm_props
`default_nettype wire

// >>> sleep_wake_manager_test.sv
// Testbench: host end and device end joined by one link, driven through the host software port.
// Assumes a 100 MHz clock and clock enables held high on both ends.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_manager_test;
    import swm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] strap = 2'h1;
    logic gpio = 1'b1;
    logic comp = 1'b0;
    logic rtc = 1'b0;
    logic wdog = 1'b0;
    logic [3:0] h_addr = 4'h0;
    logic [15:0] h_wdata = 16'h0000;
    logic h_wr = 1'b0;
    logic h_rd = 1'b0;
    logic [15:0] h_rdata;
    logic [15:0] st;
    logic irq_en;
    logic hf_en;
    logic lf_sel;
    logic retain;
    logic [3:0] sub_sleep;
    logic [1:0] state;
    int err_total = 0;
    int n_tests = 0;
    swm_if swm_if_inst ();
    swm_device swm_device_inst (.I_SYS_CLK(clk), .I_RESET(rst), .I_CLK_EN(1'b1), .I_HOST_IF_SEL(strap),
        .I_GPIO_WAKE(gpio), .I_COMP_EVT(comp), .I_RTC_TIMEOUT(rtc), .I_WDOG_IRQ(wdog), .O_HF_CLK_EN(hf_en),
        .O_AON_LF_SEL(lf_sel), .O_RAM_RETAIN(retain), .O_SUBSYS_SLEEP(sub_sleep), .O_STATE(state),
        .LINK(swm_if_inst));
    swm_host swm_host_inst (.I_SYS_CLK(clk), .I_RESET(rst), .I_CLK_EN(1'b1), .I_ADDR(h_addr),
        .I_WDATA(h_wdata), .I_WR(h_wr), .I_RD(h_rd), .O_RDATA(h_rdata), .O_IRQ_EN(irq_en), .LINK(swm_if_inst));
    swm_props swm_props_inst (.I_SYS_CLK(clk), .I_RESET(rst), .req(swm_if_inst.req), .we(swm_if_inst.we),
        .addr(swm_if_inst.addr), .wdata(swm_if_inst.wdata), .ack(swm_if_inst.ack),
        .host_irq_out(swm_if_inst.host_irq_out), .dev_rst(swm_if_inst.dev_rst), .uart_tx(swm_if_inst.uart_tx),
        .uart_tx_oe(swm_if_inst.uart_tx_oe), .uart_cts_n(swm_if_inst.uart_cts_n),
        .uart_cts_oe(swm_if_inst.uart_cts_oe), .O_HF_CLK_EN(hf_en), .O_AON_LF_SEL(lf_sel),
        .O_SUBSYS_SLEEP(sub_sleep), .O_STATE(state), .O_IRQ_EN(irq_en));
    // Free-running system clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Software port cycles: one-cycle strobes, read data taken in the cycle after
    task automatic hwr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        h_wr <= 1'b1;
        h_addr <= a;
        h_wdata <= d;
        @(posedge clk);
        h_wr <= 1'b0;
    endtask
    task automatic hrd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        h_rd <= 1'b1;
        h_addr <= a;
        @(posedge clk);
        h_rd <= 1'b0;
        #1;
        d = h_rdata;
    endtask
    // One device access through the host; a busy flag that never clears ends the run
    task automatic dev(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        hwr(HREG_ADDR, {w, 11'h000, a});
        hwr(HREG_WDATA, d);
        for (int i = 0; i < 8; i++)
        begin
            hrd(HREG_STAT, st);
            if (st[2] === 1'b0)
                break;
        end
        chk("busy", 16'(st[2]), 16'h0000);
        if (st[2] !== 1'b0)
            complete_run();
        hrd(HREG_RDATA, q);
    endtask
    task automatic wait_state(input logic [1:0] exp, input int lo, input int hi);
        int n;
        n = 0;
        while (state !== exp && n < hi)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("wake_time", 16'(n >= lo && n < hi), 16'h0001);
        if (state !== exp)
            complete_run();
    endtask
    task automatic t_boot();
        logic [15:0] q;
        #1;
        chk("dev_rst", 16'(swm_if_inst.dev_rst), 16'h0001);
        chk("tx_lines", {12'h0, swm_if_inst.uart_tx, swm_if_inst.uart_tx_oe, swm_if_inst.uart_cts_n,
            swm_if_inst.uart_cts_oe}, 16'h000D);
        hwr(HREG_CTRL, 16'h001F);  // Init bits refused while still in reset
        dev(1'b0, REG_WAKE_EN, 16'h0000, q);
        chk("irq_early", 16'(irq_en), 16'h0000);
        chk("wake_en_rst", 16'(q[4:0]), 16'(WAKE_EN_RST));
        dev(1'b0, REG_TIMEOUT, 16'h0000, q);
        chk("timeout_rst", q, TIMEOUT_RST);
        dev(1'b0, REG_STATUS, 16'h0000, q);
        chk("boot_sel", 16'(q[10:9]), 16'h0001);
        hwr(HREG_CTRL, 16'h001F);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_on", 16'(irq_en), 16'h0001);
    endtask
    // Each of the GPIO, comparator, RTC and watchdog sources alone wakes deep sleep; disabled ones and a wrong pin level do not
    task automatic t_deep();
        logic [15:0] q;
        for (int s = WK_GPIO; s < NWK; s++)
        begin
            dev(1'b1, REG_WAKE_EN, 16'(1 << s), q);
            dev(1'b1, REG_CTRL, {13'h0001, s[0], MODE_DEEP}, q);
            chk("deep", 16'(state), 16'(ST_DEEP));
            chk("retain", 16'(retain), 16'(s[0]));
            chk("irq_en_deep", 16'(irq_en), 16'h0000);
            @(posedge clk);
            strap <= 2'h2;
            comp <= (s != WK_COMP);
            rtc <= (s != WK_RTC);
            wdog <= (s != WK_WDOG);
            dev(1'b0, REG_STATUS, 16'h0000, q);
            chk("no_answer", 16'(st[1]), 16'h0001);
            chk("asleep", 16'(state), 16'(ST_DEEP));
            @(posedge clk);
            gpio <= (s != WK_GPIO);
            comp <= (s == WK_COMP);
            rtc <= (s == WK_RTC);
            wdog <= (s == WK_WDOG);
            wait_state(ST_ACTIVE, 0, 4);
            chk("irq_act", 16'(swm_if_inst.host_irq_out), 16'h0001);
            dev(1'b0, REG_STATUS, 16'h0000, q);
            chk("cause", 16'(q[7:3]), 16'(1 << s));
            chk("kept_sel", 16'(q[10:9]), 16'h0001);
            dev(1'b1, REG_IRQ_CLR, 16'h0001, q);
            chk("irq_idle", 16'(swm_if_inst.host_irq_out), 16'h0000);
            hwr(HREG_STAT, 16'h0003);
            hwr(HREG_CTRL, 16'h001F);
        end
    endtask
    // Two ticks of timeout: wake lands between one and two tick periods late
    task automatic t_timer(input logic [1:0] mode, input logic [1:0] slp);
        logic [15:0] q;
        dev(1'b1, REG_WAKE_EN, 16'h0001, q);
        dev(1'b1, REG_TIMEOUT, 16'h0002, q);
        dev(1'b1, REG_CTRL, {14'h0002, mode}, q);
        chk("timer_sleep", 16'(state), 16'(slp));
        wait_state(ST_ACTIVE, 3000, 6300);
        dev(1'b0, REG_STATUS, 16'h0000, q);
        chk("timer_cause", 16'(q[7:3]), 16'h0001);
        // Enable before the clear so the pending interrupt reaches the host
        hwr(HREG_CTRL, 16'h001F);
        dev(1'b1, REG_IRQ_CLR, 16'h0001, q);
        hrd(HREG_STAT, q);
        chk("irq_seen", 16'(q[0]), 16'h0001);
    endtask
    // Light sleep serves a command without waking, then a pin wakes it with a low-active line
    task automatic t_light();
        logic [15:0] q;
        @(posedge clk);
        gpio <= 1'b0;
        dev(1'b1, REG_WAKE_EN, 16'h0002, q);
        dev(1'b1, REG_CTRL, 16'h0011, q);
        chk("light", 16'(state), 16'(ST_LIGHT));
        chk("hf_gated", 16'(hf_en), 16'h0000);
        chk("irq_low_idle", 16'(swm_if_inst.host_irq_out), 16'h0001);
        dev(1'b0, REG_WAKE_EN, 16'h0000, q);
        chk("served", 16'(q[4:0]), 16'h0002);
        chk("still_light", 16'(state), 16'(ST_LIGHT));
        @(posedge clk);
        gpio <= 1'b1;
        wait_state(ST_ACTIVE, 0, 4);
        chk("irq_low_act", 16'(swm_if_inst.host_irq_out), 16'h0000);
        dev(1'b1, REG_IRQ_CLR, 16'h0001, q);
        dev(1'b1, REG_CTRL, 16'h0008, q);
    endtask
    // Fresh reset with the bus strap: deep sleep must be refused
    task automatic t_usb();
        logic [15:0] q;
        @(posedge clk);
        rst <= 1'b1;
        strap <= IF_USB;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        hwr(HREG_CTRL, 16'h0001);
        dev(1'b1, REG_CTRL, {14'h0002, MODE_DEEP}, q);
        chk("usb_awake", 16'(state), 16'(ST_ACTIVE));
        dev(1'b0, REG_STATUS, 16'h0000, q);
        chk("usb_refused", 16'(q[11]), 16'h0001);
        chk("usb_sel", 16'(q[10:9]), 16'(IF_USB));
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_boot();
        t_deep();
        t_timer(MODE_DEEP, ST_DEEP);
        t_timer(MODE_LIGHT, ST_LIGHT);
        t_light();
        t_usb();
        complete_run();
    end
endmodule // sleep_wake_manager_test
`default_nettype wire
